/* pmw_master.sv */
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module pmw_master
    import pmw_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    // Local master request side
    input  wire logic                   local_req_wide_n,
    input  wire logic [PMW_AD_W-1:0]    local_ad_in,
    input  wire logic [PMW_BE_W-1:0]    local_cmd_byte_en_in,
    input  wire logic [PMW_BURST_W-1:0] local_burst_len,
    input  wire logic                   local_ready_n,
    // Local master answer side
    output logic                        local_grant_n,
    output logic [PMW_STATE_W-1:0]      local_master_state,
    output logic [PMW_BURST_W-1:0]      local_burst_counter,
    output logic                        low_word_xfer_n,
    output logic                        high_word_xfer_n,
    output logic                        wide_transfer_n,
    output logic [PMW_TERM_W-1:0]       local_term_cause,
    // Arbiter
    output logic                        reqn,
    input  wire logic                   gntn,
    // Bus levels seen from the wire
    input  wire logic                   framen_i,
    input  wire logic                   irdyn_i,
    input  wire logic                   devseln,
    input  wire logic                   trdyn,
    input  wire logic                   ack64n,
    // Driven bus lines
    output logic                        framen_o,
    output logic                        framen_oe,
    output logic                        req64n_o,
    output logic                        req64n_oe,
    output logic                        irdyn_o,
    output logic                        irdyn_oe,
    output logic [PMW_AD_W-1:0]         ad_o,
    output logic                        ad_lo_oe,
    output logic                        ad_hi_oe,
    output logic [PMW_BE_W-1:0]         cben_o,
    output logic                        cben_lo_oe,
    output logic                        cben_hi_oe,
    output logic                        par_o,
    output logic                        par_oe,
    output logic                        par64_o,
    output logic                        par64_oe,
    // AXI4-Lite register slave
    input  wire logic [3:0]             s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [3:0]             s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready
);

    pmw_state_type state;
    pmw_req_type   req_hold;
    pmw_data_type  data_hold;
    logic          data_taken;
    logic          devsel_seen;
    logic [31:0]   ctrl;
    logic [31:0]   done_count;
    logic [3:0]    aw_addr;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;

    // Decoded conditions of the transaction
    wire logic bus_idle     = framen_i & irdyn_i;
    wire logic master_en    = ctrl[PMW_CTRL_EN_BIT];
    wire logic in_idle      = (state == PMW_IDLE);
    wire logic in_load      = (state == PMW_ADDR_LOAD);
    wire logic in_trans     = (state == PMW_BUS_TRANS);
    wire logic in_term      = (state == PMW_BUS_TERM);
    wire logic req_start    = in_idle & master_en & ~local_req_wide_n & reqn;
    wire logic req_drop     = ~reqn & local_req_wide_n & (~framen_o | in_idle);
    wire logic grant_go     = in_idle & ~gntn & bus_idle & ~reqn & ~local_req_wide_n;
    wire logic load_go      = in_idle & ~local_req_wide_n & ~local_grant_n;
    wire logic addr_go      = in_load & ~gntn;
    wire logic strobe_go    = ~local_ready_n & ~data_taken & low_word_xfer_n
                              & (addr_go | in_trans);
    wire logic strobe_now   = ~low_word_xfer_n & ~high_word_xfer_n;
    wire logic width_go     = in_trans & ~devsel_seen & ~devseln;
    wire logic irdy_go      = in_trans & devsel_seen & data_taken & ~local_ready_n
                              & irdyn_o & ~framen_o;
    wire logic phase_done   = in_trans & ~irdyn_o & ~trdyn;

    // Parity of what the bus carries in this clock
    wire logic par_lo_next;
    wire logic par_hi_next;

    pmw_parity u_par_lo (
        .ad_half   (ad_o[31:0]),
        .cben_half (cben_o[3:0]),
        .par       (par_lo_next)
    );

    pmw_parity u_par_hi (
        .ad_half   (ad_o[63:32]),
        .cben_half (cben_o[7:4]),
        .par       (par_hi_next)
    );

    // Transaction state and local status
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= PMW_IDLE;
        end else if (load_go) begin
            state <= PMW_ADDR_LOAD;
        end else if (addr_go) begin
            state <= PMW_BUS_TRANS;
        end else if (phase_done) begin
            state <= PMW_BUS_TERM;
        end else if (in_term) begin
            state <= PMW_IDLE;
        end
    end

    assign local_master_state = state;

    // Arbiter request
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reqn <= 1'b1;
        end else if (req_start) begin
            reqn <= 1'b0;
        end else if (req_drop) begin
            reqn <= 1'b1;
        end
    end

    // Local grant, later following gntn
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            local_grant_n <= 1'b1;
        end else if (in_idle) begin
            local_grant_n <= ~grant_go;
        end else if (width_go & ~ack64n & ~trdyn) begin
            local_grant_n <= gntn;
        end else if (phase_done) begin
            local_grant_n <= 1'b1;
        end
    end

    // Latched address, command and burst length
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            req_hold <= '0;
        end else if (load_go) begin
            req_hold.addr  <= local_ad_in[31:0];
            req_hold.cmd   <= local_cmd_byte_en_in[PMW_CMD_W-1:0];
            req_hold.burst <= local_burst_len;
        end
    end

    // Burst counter
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            local_burst_counter <= '0;
        end else if (addr_go) begin
            local_burst_counter <= req_hold.burst;
        end else if (phase_done & (local_burst_counter != '0)) begin
            local_burst_counter <= local_burst_counter - 1'b1;
        end
    end

    // Word strobes towards the local master
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            low_word_xfer_n  <= 1'b1;
            high_word_xfer_n <= 1'b1;
        end else begin
            low_word_xfer_n  <= ~strobe_go;
            high_word_xfer_n <= ~strobe_go;
        end
    end

    // Write data taken while the strobes are low
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            data_hold  <= '0;
            data_taken <= 1'b0;
        end else if (in_term) begin
            data_taken <= 1'b0;
        end else if (strobe_now) begin
            data_hold.data <= local_ad_in;
            data_hold.be   <= local_cmd_byte_en_in;
            data_taken     <= 1'b1;
        end
    end

    // Width decision once devseln is seen
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            devsel_seen     <= 1'b0;
            wide_transfer_n <= 1'b1;
        end else if (in_term) begin
            devsel_seen     <= 1'b0;
            wide_transfer_n <= 1'b1;
        end else if (width_go) begin
            devsel_seen     <= 1'b1;
            wide_transfer_n <= ack64n | trdyn;
        end
    end

    // Frame and 64-bit request
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            framen_o  <= 1'b1;
            framen_oe <= 1'b0;
            req64n_o  <= 1'b1;
            req64n_oe <= 1'b0;
        end else if (addr_go) begin
            framen_o  <= 1'b0;
            framen_oe <= 1'b1;
            req64n_o  <= 1'b0;
            req64n_oe <= 1'b1;
        end else if (irdy_go) begin
            framen_o <= 1'b1;
            req64n_o <= 1'b1;
        end else if (phase_done) begin
            framen_oe <= 1'b0;
            req64n_oe <= 1'b0;
        end
    end

    // Initiator ready
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irdyn_o  <= 1'b1;
            irdyn_oe <= 1'b0;
        end else if (addr_go) begin
            irdyn_o  <= 1'b1;
            irdyn_oe <= 1'b1;
        end else if (irdy_go) begin
            irdyn_o <= 1'b0;
        end else if (phase_done) begin
            irdyn_o <= 1'b1;
        end else if (in_term) begin
            irdyn_oe <= 1'b0;
        end
    end

    // Address and data lines with command and byte enables
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ad_o       <= '0;
            cben_o     <= '0;
            ad_lo_oe   <= 1'b0;
            ad_hi_oe   <= 1'b0;
            cben_lo_oe <= 1'b0;
            cben_hi_oe <= 1'b0;
        end else if (addr_go) begin
            ad_o       <= {32'h0000_0000, req_hold.addr};
            cben_o     <= {4'h0, req_hold.cmd};
            ad_lo_oe   <= 1'b1;
            cben_lo_oe <= 1'b1;
        end else if (in_trans & strobe_now) begin
            ad_o       <= local_ad_in;
            cben_o     <= local_cmd_byte_en_in;
            ad_hi_oe   <= 1'b1;
            cben_hi_oe <= 1'b1;
        end else if (phase_done) begin
            ad_lo_oe   <= 1'b0;
            ad_hi_oe   <= 1'b0;
            cben_lo_oe <= 1'b0;
            cben_hi_oe <= 1'b0;
        end
    end

    // Parity trails its lines by one clock
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            par_o    <= 1'b0;
            par_oe   <= 1'b0;
            par64_o  <= 1'b0;
            par64_oe <= 1'b0;
        end else begin
            par_o    <= par_lo_next;
            par_oe   <= ad_lo_oe;
            par64_o  <= par_hi_next;
            par64_oe <= ad_hi_oe;
        end
    end

    // Termination cause
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            local_term_cause <= PMW_TERM_NONE;
        end else if (addr_go) begin
            local_term_cause <= PMW_TERM_NONE;
        end else if (phase_done) begin
            local_term_cause <= PMW_TERM_NORMAL;
        end
    end

    // Completed transaction count
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            done_count <= '0;
        end else if (phase_done) begin
            done_count <= done_count + 32'h0000_0001;
        end
    end

    // Register read mux and write decode
    wire logic        wr_go     = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
    wire logic        wr_ctrl   = (aw_addr == PMW_OFS_CTRL);
    wire logic        wr_known  = wr_ctrl | (aw_addr == PMW_OFS_STATUS)
                                  | (aw_addr == PMW_OFS_COUNT);
    wire logic        rd_ctrl   = (s_axi_araddr == PMW_OFS_CTRL);
    wire logic        rd_stat   = (s_axi_araddr == PMW_OFS_STATUS);
    wire logic        rd_count  = (s_axi_araddr == PMW_OFS_COUNT);
    wire logic        rd_known  = rd_ctrl | rd_stat | rd_count;
    wire logic [31:0] stat_word = {14'h0000, ~local_grant_n, ~reqn,
                                   local_burst_counter, ~wide_transfer_n,
                                   local_term_cause, local_master_state};
    wire logic [31:0] rd_word   = rd_ctrl  ? ctrl :
                                  rd_stat  ? stat_word :
                                  rd_count ? done_count : 32'h0000_0000;

    // Write address and data, taken in either order
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            aw_addr       <= '0;
            w_data        <= '0;
            w_strb        <= '0;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                s_axi_awready <= 1'b0;
                aw_addr       <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                s_axi_wready <= 1'b0;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
            end
            if (s_axi_bvalid & s_axi_bready) begin
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Write response and control register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= PMW_RESP_OKAY;
            ctrl         <= PMW_CTRL_RESET;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? PMW_RESP_OKAY : PMW_RESP_SLVERR;
            if (wr_ctrl & w_strb[0]) begin
                ctrl <= {31'h0000_0000, w_data[PMW_CTRL_EN_BIT]};
            end
        end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read channel
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= PMW_RESP_OKAY;
        end else if (s_axi_arvalid & s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_known ? PMW_RESP_OKAY : PMW_RESP_SLVERR;
        end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule

/* pmw_pkg.sv */
`timescale 1ns/100ps
// How it works
// - One clock after seeing the local request, reqn is asserted.
// - With gntn asserted and the bus idle, the local grant is asserted.
// - Request and grant seen together: state goes to address loading, request latched.
// - Grant during address loading: framen, req64n, address and command driven, state bus-transaction.
// - Address phase loads the burst counter from the latched burst length.
// - With local_ready_n asserted during address loading, both word strobes assert in the address phase while data is taken.
// - Frame asserted and local request released: reqn is deasserted.
// - Clock after the strobes, both data words and byte enables go onto the bus.
// - First data phase keeps framen asserted and irdyn off while width is judged.
// - ack64n and trdyn seen: wide indicator asserts, local grant follows gntn.
// - Ready seen: irdyn asserts, framen deasserts; phase ends when irdyn and trdyn meet.
// - Turnaround releases framen, req64n, ad and cben, and deasserts irdyn.
// - Turnaround counts the burst down, state bus-termination, cause normal.
// - Idle clock after turnaround releases irdyn, par and par64.
package pmw_pkg;

    // Widths of the local and bus sides
    localparam int PMW_AD_W    = 64;
    localparam int PMW_BE_W    = 8;
    localparam int PMW_CMD_W   = 4;
    localparam int PMW_BURST_W = 8;
    localparam int PMW_STATE_W = 4;
    localparam int PMW_TERM_W  = 3;

    // Register map, byte addresses
    localparam logic [3:0]  PMW_OFS_CTRL   = 4'h0;
    localparam logic [3:0]  PMW_OFS_STATUS = 4'h4;
    localparam logic [3:0]  PMW_OFS_COUNT  = 4'h8;
    localparam logic [31:0] PMW_CTRL_RESET = 32'h0000_0001;
    localparam int          PMW_CTRL_EN_BIT = 0;

    // Status word field positions
    localparam int PMW_ST_STATE_LSB = 0;
    localparam int PMW_ST_TERM_LSB  = 4;
    localparam int PMW_ST_WIDE_BIT  = 7;
    localparam int PMW_ST_BURST_LSB = 8;
    localparam int PMW_ST_REQ_BIT   = 16;
    localparam int PMW_ST_GNT_BIT   = 17;

    // Bus answers
    localparam logic [1:0] PMW_RESP_OKAY   = 2'h0;
    localparam logic [1:0] PMW_RESP_SLVERR = 2'h2;

    // Local status values
    typedef enum logic [3:0] {
        PMW_IDLE      = 4'h0,
        PMW_ADDR_LOAD = 4'h1,
        PMW_BUS_TRANS = 4'h2,
        PMW_BUS_TERM  = 4'h3
    } pmw_state_type;

    // Termination causes
    typedef enum logic [2:0] {
        PMW_TERM_NONE   = 3'h0,
        PMW_TERM_NORMAL = 3'h1
    } pmw_term_type;

    // Latched local request
    typedef struct packed {
        logic [31:0]            addr;
        logic [PMW_CMD_W-1:0]   cmd;
        logic [PMW_BURST_W-1:0] burst;
    } pmw_req_type;

    // Latched write data with its byte enables
    typedef struct packed {
        logic [PMW_AD_W-1:0] data;
        logic [PMW_BE_W-1:0] be;
    } pmw_data_type;

endpackage

// Even parity over one 32-bit half of ad and its four byte enables
module pmw_parity
    import pmw_pkg::*;
(
    // Half of the bus
    input  wire logic [31:0] ad_half,
    input  wire logic [3:0]  cben_half,
    // Parity result
    output wire logic        par
);

    assign par = ^{ad_half, cben_half};

endmodule

/* pmw_monitor.sv */
`timescale 1ns/100ps
module pmw_monitor
    import pmw_pkg::*;
(
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       rst,
    // Local side
    input wire logic       local_req_wide_n,
    input wire logic [7:0] local_burst_len,
    input wire logic       local_ready_n,
    input wire logic       local_grant_n,
    input wire logic [3:0] local_master_state,
    input wire logic [7:0] local_burst_counter,
    input wire logic       wide_transfer_n,
    input wire logic [2:0] local_term_cause,
    // Bus side
    input wire logic       reqn,
    input wire logic       gntn,
    input wire logic       framen_i,
    input wire logic       irdyn_i,
    input wire logic       trdyn,
    input wire logic       ack64n,
    input wire logic       framen_o,
    input wire logic       framen_oe,
    input wire logic       req64n_o,
    input wire logic       irdyn_o,
    input wire logic       irdyn_oe,
    input wire logic       ad_lo_oe,
    input wire logic       ad_hi_oe,
    input wire logic       par_oe,
    input wire logic       par64_oe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    // State decodes
    wire st_idle = local_master_state == PMW_IDLE;
    wire st_load = local_master_state == PMW_ADDR_LOAD;
    wire st_tran = local_master_state == PMW_BUS_TRANS;
    wire st_term = local_master_state == PMW_BUS_TERM;

    // Address loading then address phase
    sequence s_load;
        st_load ##1 st_tran;
    endsequence

    AST_REQ: assert property (!local_req_wide_n && st_idle && local_grant_n && reqn
        |=> !reqn) else $error("arbiter request missing");
    AST_GRANT: assert property (!gntn && framen_i && irdyn_i && !reqn && !local_req_wide_n
        && st_idle |=> !local_grant_n) else $error("local grant missing");
    AST_LOAD: assert property (!local_req_wide_n && !local_grant_n && st_idle |=> st_load)
        else $error("address loading missed");
    AST_ADDR: assert property (!gntn && st_load |=> st_tran && !framen_o && framen_oe
        && !req64n_o && ad_lo_oe) else $error("address phase wrong");
    AST_BURST: assert property (s_load |-> local_burst_counter == $past(local_burst_len, 2))
        else $error("burst counter not loaded");
    AST_WAIT: assert property ($fell(framen_o) |=> !framen_o && irdyn_o)
        else $error("first data phase not held");
    AST_WIDE: assert property (!ack64n && !trdyn && st_tran && irdyn_i |=> !wide_transfer_n)
        else $error("wide indicator missing");
    AST_IRDY: assert property (!wide_transfer_n && !framen_o && framen_oe && !local_ready_n
        && ad_hi_oe |=> !irdyn_o && framen_o) else $error("ready not passed to bus");
    AST_TERM: assert property (!irdyn_i && !trdyn && st_tran |=> st_term && irdyn_o
        && local_term_cause == PMW_TERM_NORMAL && !framen_oe && !ad_lo_oe && !ad_hi_oe
        && local_burst_counter == $past(local_burst_counter) - 8'h01)
        else $error("termination wrong");
    AST_IDLE: assert property (st_term |=> st_idle && !irdyn_oe && !par_oe && !par64_oe)
        else $error("bus lines not released");
endmodule

/* pmw_far_end.sv */
`timescale 1ns/100ps
module pmw_far_end (
    // Clock, reset and pace
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic slow,
    // Bus levels
    input wire logic reqn,
    input wire logic framen_i,
    input wire logic irdyn_i,
    // Arbiter and target answers
    output logic     gntn,
    output logic     devseln,
    output logic     trdyn,
    output logic     ack64n
);
    logic [2:0] wait_cnt;

    // Arbiter, prompt or three clocks late
    always_ff @(posedge clk_sys) begin
        if (rst || reqn) begin
            wait_cnt <= 3'h0;
            gntn     <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 3'h1;
            if (wait_cnt >= (slow ? 3'h3 : 3'h0)) gntn <= 1'b0;
        end
    end

    // Fast decode 64-bit target
    always_ff @(posedge clk_sys) begin
        if (rst || (!irdyn_i && !trdyn)) begin
            {devseln, trdyn, ack64n} <= 3'h7;
        end else if (!framen_i && devseln && irdyn_i) begin
            {devseln, trdyn, ack64n} <= 3'h0;
        end
    end
endmodule

/* pci_master_64bit_single_write_bench.sv */
`timescale 1ns/100ps
module pci_master_64bit_single_write_bench
    import pmw_pkg::*;
;
    typedef struct {
        logic [31:0] a;
        logic [3:0]  c;
        logic [7:0]  n;
        logic [63:0] d;
        logic [7:0]  b;
        int          rd;
        logic        slow;
        logic [7:0]  e;
    } pmw_row_type;

    logic clk_sys, rst, slow, local_req_wide_n, local_ready_n, local_grant_n, reqn, gntn;
    logic [63:0] local_ad_in, ad_o;
    logic [7:0] local_cmd_byte_en_in, local_burst_len, local_burst_counter, cben_o;
    logic [3:0] local_master_state, s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
    logic [2:0] local_term_cause;
    logic low_word_xfer_n, high_word_xfer_n, wide_transfer_n, framen_i, irdyn_i;
    logic devseln, trdyn, ack64n, framen_o, framen_oe, req64n_o, req64n_oe, irdyn_o;
    logic irdyn_oe, ad_lo_oe, ad_hi_oe, cben_lo_oe, cben_hi_oe, par_o, par_oe, par64_o;
    logic par64_oe, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    int fails, checks_done, cyc;
    pmw_row_type rows[3] = '{
        '{32'h1000_0000, 4'h7, 8'h01, 64'h0123_4567_89ab_cdef, 8'h00, 0, 1'b0, 8'h00},
        '{32'h2000_0040, 4'h7, 8'hff, 64'hfedc_ba98_7654_3210, 8'h0f, 2, 1'b1, 8'hfe},
        '{32'h3000_0ff8, 4'hf, 8'h02, 64'h5555_aaaa_0f0f_f0f0, 8'hf0, 1, 1'b0, 8'h01}};

    // Pulled-up bus wires
    assign framen_i = framen_oe ? framen_o : 1'b1;
    assign irdyn_i = irdyn_oe ? irdyn_o : 1'b1;

    pmw_master u_dut (.*);
    pmw_far_end u_far (.clk_sys(clk_sys), .rst(rst), .slow(slow), .reqn(reqn),
        .framen_i(framen_i), .irdyn_i(irdyn_i), .gntn(gntn), .devseln(devseln),
        .trdyn(trdyn), .ack64n(ack64n));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // Hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 4000) begin
            fails++;
            results;
        end
    end

    task results;
        if (fails == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task chk(input string n, input logic [79:0] e, input logic [79:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task axw(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        forever begin
            @(posedge clk_sys);
            if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task axr(input logic [3:0] a);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        forever begin
            @(posedge clk_sys);
            if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        {rd, rsp} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
    endtask

    task wt(input pmw_state_type s);
        do begin
            @(posedge clk_sys);
            #1;
        end while (local_master_state !== s);
    endtask

    task xfer(input pmw_row_type r);
        @(posedge clk_sys);
        local_req_wide_n <= 1'b0;
        {local_ad_in, local_cmd_byte_en_in} <= {32'h0, r.a, 4'h0, r.c};
        {local_burst_len, slow} <= {r.n, r.slow};
        wt(PMW_ADDR_LOAD);
        // Early ready, strobes fall in the address phase
        if (r.rd == 0) begin
            local_ready_n <= 1'b0;
            {local_ad_in, local_cmd_byte_en_in} <= {r.d, r.b};
        end
        @(posedge clk_sys);
        local_req_wide_n <= 1'b1;
        #1;
        chk("address", {r.a, r.c}, {ad_o[31:0], cben_o[3:0]});
        chk("counter", r.n, local_burst_counter);
        repeat (r.rd) @(posedge clk_sys);
        local_ready_n <= 1'b0;
        {local_ad_in, local_cmd_byte_en_in} <= {r.d, r.b};
        while (low_word_xfer_n !== 1'b0) begin
            @(posedge clk_sys);
            #1;
        end
        chk("high strobe", 0, high_word_xfer_n);
        @(posedge clk_sys);
        #1;
        chk("data", {r.d, r.b, 2'h3}, {ad_o, cben_o, ad_hi_oe, cben_hi_oe});
        chk("parity", {^{r.a, r.c}, 1'b0}, {par_o, par64_o});
        wt(PMW_BUS_TERM);
        chk("cause", PMW_TERM_NORMAL, local_term_cause);
        chk("end counter", r.e, local_burst_counter);
        chk("released", 3'h0, {framen_oe, req64n_oe, wide_transfer_n});
        local_ready_n <= 1'b1;
        wt(PMW_IDLE);
        chk("idle lines", 4'h1, {irdyn_oe, par_oe, par64_oe, reqn});
    endtask

    initial begin
        {rst, local_req_wide_n, local_ready_n, s_axi_wstrb} = 7'h7f;
        {local_ad_in, local_cmd_byte_en_in, local_burst_len, slow} = '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        axr(PMW_OFS_CTRL);
        chk("ctrl reset", {PMW_CTRL_RESET, PMW_RESP_OKAY}, {rd, rsp});
        axw(PMW_OFS_CTRL, 32'h1);
        chk("ctrl write", PMW_RESP_OKAY, rsp);
        foreach (rows[i]) xfer(rows[i]);
        axr(PMW_OFS_COUNT);
        chk("count", {32'h3, PMW_RESP_OKAY}, {rd, rsp});
        axr(PMW_OFS_STATUS);
        chk("status", {4'h0, PMW_RESP_OKAY}, {rd[3:0], rsp});
        axw(PMW_OFS_STATUS, 32'hf);
        chk("ro write", PMW_RESP_OKAY, rsp);
        axw(4'hc, 32'h1);
        chk("unmapped write", PMW_RESP_SLVERR, rsp);
        axr(4'hc);
        chk("unmapped read", PMW_RESP_SLVERR, rsp);
        // Reset in the middle of a transfer, then recover
        @(posedge clk_sys);
        local_req_wide_n <= 1'b0;
        local_ad_in <= {32'h0, rows[0].a};
        wt(PMW_BUS_TRANS);
        {rst, local_req_wide_n} <= 2'h3;
        @(posedge clk_sys);
        #1;
        rst <= 1'b0;
        chk("reset", {1'b1, PMW_IDLE, 1'b0}, {reqn, local_master_state, framen_oe});
        xfer(rows[2]);
        results;
    end
endmodule

bind pmw_master pmw_monitor u_mon (.*);
